// ==== design/wide_acc_alu.sv ====
// fixed-point datapath around a 64-bit accumulator operand, one registered result per request
`timescale 1ns/1ps
module wide_acc_alu
  import wide_alu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // request from the pipeline
  input wire logic req_valid,
  input wire alu_req_s req,
  // overflow flag control
  input wire logic ovf_clear,
  // registered answer
  output logic res_valid,
  output logic [WIDE_W-1:0] result,
  output logic [WORD_W-1:0] result_word,
  output logic [HALF_W-1:0] result_half,
  output logic sat_event,
  output logic ovf_flag
);

  logic [WORD_W-1:0] mul_a;
  logic [WORD_W-1:0] mul_b;
  logic [WIDE_W-1:0] product;
  logic [WIDE_W-1:0] prod_frac16;
  logic [WIDE_W-1:0] prod_frac32;
  logic frac32_sat;
  logic [WIDE_W-1:0] lshl_value;
  logic [WIDE_W-1:0] lshr_value;
  logic [WORD_W-1:0] shl_word;
  logic shl_hit;
  logic [WIDE_W-1:0] acc_mid;
  sat_sum_s add_r;
  sat_sum_s sub_r;
  sat_sum_s neg_r;
  sat_sum_s rnd_mid_r;
  sat_sum_s rnd_top_r;
  logic [WIDE_W-1:0] rnd_mid_shift;
  logic [WIDE_W-1:0] rnd_top_shift;
  logic [WIDE_W-1:0] next_value;
  logic next_sat;
  logic next_ovf_set;
  logic [WORD_W-1:0] acc_word_sat;
  logic [WORD_W-1:0] acc_mid_sat;
  logic [WORD_W-1:0] rnd_mid_word;
  logic [HALF_W-1:0] rnd_top_half;
  logic lead_hit [WIDE_W];
  logic [NORM_W-1:0] lead_part [WIDE_W];
  logic [NORM_W-1:0] lead_count;

  // halfword operations run through the same multiplier, sign-extended
  always_comb begin
    case (req.op)
      OP_MUL16_INT, OP_MAC16_INT, OP_MSU16_INT, OP_MUL16_FRAC, OP_MAC16_FRAC, OP_MSU16_FRAC: begin
        mul_a = {{(WORD_W-HALF_W){req.half_a[HALF_W-1]}}, req.half_a};
        mul_b = {{(WORD_W-HALF_W){req.half_b[HALF_W-1]}}, req.half_b};
      end
      default: begin
        mul_a = req.word_a;
        mul_b = req.word_b;
      end
    endcase
  end

  wide_multiplier u_mul (
    .mul_a(mul_a),
    .mul_b(mul_b),
    .product(product)
  );

  wide_shifter u_shift (
    .value(req.acc),
    .count(req.count),
    .lshl_value(lshl_value),
    .lshr_value(lshr_value),
    .sat_word(shl_word),
    .sat_hit(shl_hit)
  );

  // a 16x16 product doubled always fits, so no clamp is needed there
  always_comb begin
    prod_frac16 = product << FRAC_SHIFT;
    frac32_sat = (req.word_a == WORD_MIN) && (req.word_b == WORD_MIN);
    prod_frac32 = frac32_sat ? WIDE_MAX : (product << FRAC_SHIFT);
  end

  always_comb begin
    add_r = sat_add64(req.acc, req.wide_b);
    sub_r = sat_sub64(req.acc, req.wide_b);
    neg_r = sat_sub64(WIDE_ZERO, req.acc);
  end

  always_comb begin
    acc_mid = $signed(req.acc) >>> MID_SHIFT;
    rnd_mid_r = sat_add64(req.acc, ROUND_MID);
    rnd_top_r = sat_add64(req.acc, ROUND_TOP);
    rnd_mid_shift = $signed(rnd_mid_r.value) >>> MID_SHIFT;
    rnd_top_shift = $signed(rnd_top_r.value) >>> TOP_SHIFT;
    acc_word_sat = clamp_word(req.acc);
    acc_mid_sat = clamp_word(acc_mid);
    rnd_mid_word = clamp_word(rnd_mid_shift);
    rnd_top_half = clamp_half(rnd_top_shift);
  end

  // leading-sign scan from just below the sign bit down; the first differing bit fixes the count
  assign lead_hit[WIDE_W-1] = 1'b0;
  assign lead_part[WIDE_W-1] = '0;

  for (genvar i = 0; i < WIDE_W - 1; i++) begin : g_lead
    logic differs;
    assign differs = req.acc[i] ^ req.acc[WIDE_W-1];
    assign lead_hit[i] = lead_hit[i+1] | differs;
    assign lead_part[i] = (differs && !lead_hit[i+1]) ? NORM_W'(WIDE_W - 2 - i) : lead_part[i+1];
  end

  // all bits equal the sign: zero stays zero, minus one needs the full count
  assign lead_count = lead_hit[0] ? lead_part[0] : ((req.acc == WIDE_ZERO) ? '0 : NORM_W'(WIDE_W - 1));

  always_comb begin
    next_value = WIDE_ZERO;
    case (req.op)
      OP_MUL16_INT: begin
        next_value = product;
      end
      OP_MAC16_INT: begin
        next_value = req.acc + product;
      end
      OP_MSU16_INT: begin
        next_value = req.acc - product;
      end
      OP_MUL16_FRAC: begin
        next_value = prod_frac16;
      end
      OP_MAC16_FRAC: begin
        next_value = req.acc + prod_frac16;
      end
      OP_MSU16_FRAC: begin
        next_value = req.acc - prod_frac16;
      end
      OP_DEPOSIT_LO: begin
        next_value = {{(WIDE_W-WORD_W){req.word_a[WORD_W-1]}}, req.word_a};
      end
      OP_DEPOSIT_HI: begin
        next_value = {req.word_a, {(WIDE_W-WORD_W){1'b0}}};
      end
      OP_SAT_WORD: begin
        next_value = {{(WIDE_W-WORD_W){acc_word_sat[WORD_W-1]}}, acc_word_sat};
      end
      OP_SAT_MID: begin
        next_value = {{(WIDE_W-WORD_W){acc_mid_sat[WORD_W-1]}}, acc_mid_sat};
      end
      OP_SHL_SAT_WORD: begin
        next_value = {{(WIDE_W-WORD_W){shl_word[WORD_W-1]}}, shl_word};
      end
      OP_EXTRACT_LO: begin
        next_value = {{(WIDE_W-WORD_W){req.acc[WORD_W-1]}}, req.acc[WORD_W-1:0]};
      end
      OP_EXTRACT_HI: begin
        next_value = {{(WIDE_W-WORD_W){req.acc[WIDE_W-1]}}, req.acc[WIDE_W-1:WORD_W]};
      end
      OP_ROUND_MID: begin
        next_value = {{(WIDE_W-WORD_W){rnd_mid_word[WORD_W-1]}}, rnd_mid_word};
      end
      OP_ROUND_HALF: begin
        next_value = {{(WIDE_W-HALF_W){rnd_top_half[HALF_W-1]}}, rnd_top_half};
      end
      OP_ROUND_TOP: begin
        next_value = rnd_top_shift;
      end
      OP_NORM: begin
        next_value = {{(WIDE_W-NORM_W){1'b0}}, lead_count};
      end
      OP_ADD_SAT: begin
        next_value = add_r.value;
      end
      OP_SUB_SAT: begin
        next_value = sub_r.value;
      end
      OP_NEG_SAT: begin
        next_value = neg_r.value;
      end
      OP_ABS_SAT: begin
        next_value = req.acc[WIDE_W-1] ? neg_r.value : req.acc;
      end
      OP_MUL32_FRAC: begin
        next_value = prod_frac32;
      end
      OP_MUL32_INT: begin
        next_value = product;
      end
      OP_LSHL: begin
        next_value = lshl_value;
      end
      OP_LSHR: begin
        next_value = lshr_value;
      end
      default: begin
        next_value = WIDE_ZERO;
      end
    endcase
  end

  // clamp pulse for every operation that had to saturate, except a negative-count OP_SHL_SAT_WORD whose clamp equals the shifted low word
  always_comb begin
    next_sat = 1'b0;
    case (req.op)
      OP_SAT_WORD: begin
        next_sat = (acc_word_sat != req.acc[WORD_W-1:0]) || (req.acc != next_value);
      end
      OP_SAT_MID: begin
        next_sat = (acc_mid != next_value);
      end
      OP_SHL_SAT_WORD: begin
        next_sat = shl_hit;
      end
      OP_ROUND_MID: begin
        next_sat = rnd_mid_r.ovf || (rnd_mid_shift != next_value);
      end
      OP_ROUND_HALF: begin
        next_sat = rnd_top_r.ovf || (rnd_top_shift != next_value);
      end
      OP_ROUND_TOP: begin
        next_sat = rnd_top_r.ovf;
      end
      OP_ADD_SAT: begin
        next_sat = add_r.ovf;
      end
      OP_SUB_SAT: begin
        next_sat = sub_r.ovf;
      end
      OP_NEG_SAT: begin
        next_sat = neg_r.ovf;
      end
      OP_ABS_SAT: begin
        next_sat = req.acc[WIDE_W-1] && neg_r.ovf;
      end
      OP_MUL32_FRAC: begin
        next_sat = frac32_sat;
      end
      default: begin
        next_sat = 1'b0;
      end
    endcase
  end

  // only the saturating add, subtract and negate raise the sticky flag
  always_comb begin
    next_ovf_set = 1'b0;
    case (req.op)
      OP_ADD_SAT: begin
        next_ovf_set = add_r.ovf;
      end
      OP_SUB_SAT: begin
        next_ovf_set = sub_r.ovf;
      end
      OP_NEG_SAT: begin
        next_ovf_set = neg_r.ovf;
      end
      default: begin
        next_ovf_set = 1'b0;
      end
    endcase
  end

  // answer registered on the edge after the request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_valid <= 1'b0;
    end else begin
      res_valid <= req_valid;
    end
  end

  // results hold between requests
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      result <= WIDE_ZERO;
      result_word <= '0;
      result_half <= '0;
    end else if (req_valid) begin
      result <= next_value;
      result_word <= next_value[WORD_W-1:0];
      result_half <= next_value[HALF_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sat_event <= 1'b0;
    end else begin
      sat_event <= req_valid && next_sat;
    end
  end

  // sticky overflow; a new overflow beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_flag <= 1'b0;
    end else if (req_valid && next_ovf_set) begin
      ovf_flag <= 1'b1;
    end else if (ovf_clear) begin
      ovf_flag <= 1'b0;
    end
  end

endmodule : wide_acc_alu

// ==== design/wide_alu_pkg.sv ====
// constants, operation codes, carriers and helper functions for the wide accumulator alu
package wide_alu_pkg;

  localparam int WIDE_W = 64;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int CNT_W = 16;
  localparam int NORM_W = 6;
  localparam int AMT_W = 7;
  localparam int MID_SHIFT = 16;
  localparam int TOP_SHIFT = 32;
  localparam int FRAC_SHIFT = 1;
  localparam logic [CNT_W-1:0] SHIFT_LIMIT = 16'h0040;
  localparam logic [AMT_W-1:0] AMT_FULL = 7'h40;
  localparam logic [AMT_W-1:0] AMT_SIGN = 7'h3f;

  localparam logic [WIDE_W-1:0] WIDE_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [WIDE_W-1:0] WIDE_MAX = 64'h7fff_ffff_ffff_ffff;
  localparam logic [WIDE_W-1:0] WIDE_MIN = 64'h8000_0000_0000_0000;
  localparam logic [WORD_W-1:0] WORD_MAX = 32'h7fff_ffff;
  localparam logic [WORD_W-1:0] WORD_MIN = 32'h8000_0000;
  localparam logic [HALF_W-1:0] HALF_MAX = 16'h7fff;
  localparam logic [HALF_W-1:0] HALF_MIN = 16'h8000;
  localparam logic [WIDE_W-1:0] ROUND_MID = 64'h0000_0000_0000_8000;
  localparam logic [WIDE_W-1:0] ROUND_TOP = 64'h0000_0000_8000_0000;

  typedef enum logic [4:0] {
    OP_MUL16_INT = 5'h00,
    OP_MAC16_INT = 5'h01,
    OP_MSU16_INT = 5'h02,
    OP_MUL16_FRAC = 5'h03,
    OP_MAC16_FRAC = 5'h04,
    OP_MSU16_FRAC = 5'h05,
    OP_DEPOSIT_LO = 5'h06,
    OP_DEPOSIT_HI = 5'h07,
    OP_SAT_WORD = 5'h08,
    OP_SAT_MID = 5'h09,
    OP_SHL_SAT_WORD = 5'h0a,
    OP_EXTRACT_LO = 5'h0b,
    OP_EXTRACT_HI = 5'h0c,
    OP_ROUND_MID = 5'h0d,
    OP_ROUND_HALF = 5'h0e,
    OP_ROUND_TOP = 5'h0f,
    OP_NORM = 5'h10,
    OP_ADD_SAT = 5'h11,
    OP_SUB_SAT = 5'h12,
    OP_NEG_SAT = 5'h13,
    OP_ABS_SAT = 5'h14,
    OP_MUL32_FRAC = 5'h15,
    OP_MUL32_INT = 5'h16,
    OP_LSHL = 5'h17,
    OP_LSHR = 5'h18
  } alu_op_e;

  typedef struct packed {
    alu_op_e op;
    logic [WIDE_W-1:0] acc;
    logic [WIDE_W-1:0] wide_b;
    logic [WORD_W-1:0] word_a;
    logic [WORD_W-1:0] word_b;
    logic [HALF_W-1:0] half_a;
    logic [HALF_W-1:0] half_b;
    logic [CNT_W-1:0] count;
  } alu_req_s;

  typedef struct packed {
    logic [WIDE_W-1:0] value;
    logic ovf;
  } sat_sum_s;

  function automatic sat_sum_s sat_add64(input logic [WIDE_W-1:0] a, input logic [WIDE_W-1:0] b);
    sat_sum_s r;
    logic [WIDE_W-1:0] sum;
    sum = a + b;
    r.ovf = (a[WIDE_W-1] == b[WIDE_W-1]) && (sum[WIDE_W-1] != a[WIDE_W-1]);
    r.value = r.ovf ? (a[WIDE_W-1] ? WIDE_MIN : WIDE_MAX) : sum;
    return r;
  endfunction : sat_add64

  function automatic sat_sum_s sat_sub64(input logic [WIDE_W-1:0] a, input logic [WIDE_W-1:0] b);
    sat_sum_s r;
    logic [WIDE_W-1:0] diff;
    diff = a - b;
    r.ovf = (a[WIDE_W-1] != b[WIDE_W-1]) && (diff[WIDE_W-1] != a[WIDE_W-1]);
    r.value = r.ovf ? (a[WIDE_W-1] ? WIDE_MIN : WIDE_MAX) : diff;
    return r;
  endfunction : sat_sub64

  // clamp to the signed word range
  function automatic logic [WORD_W-1:0] clamp_word(input logic [WIDE_W-1:0] x);
    logic fits;
    fits = (x[WIDE_W-1:WORD_W-1] == '0) || (x[WIDE_W-1:WORD_W-1] == '1);
    return fits ? x[WORD_W-1:0] : (x[WIDE_W-1] ? WORD_MIN : WORD_MAX);
  endfunction : clamp_word

  function automatic logic [HALF_W-1:0] clamp_half(input logic [WIDE_W-1:0] x);
    logic fits;
    fits = (x[WIDE_W-1:HALF_W-1] == '0) || (x[WIDE_W-1:HALF_W-1] == '1);
    return fits ? x[HALF_W-1:0] : (x[WIDE_W-1] ? HALF_MIN : HALF_MAX);
  endfunction : clamp_half

  // redundant sign bits below the sign; -1 gives the full count
  function automatic logic [NORM_W-1:0] norm64(input logic [WIDE_W-1:0] x);
    logic [WIDE_W-1:0] y;
    logic [AMT_W-1:0] n;
    logic found;
    y = x[WIDE_W-1] ? ~x : x;
    n = '0;
    found = 1'b0;
    for (int i = WIDE_W - 2; i >= 0; i--) begin
      if (!found) begin
        if (y[i]) begin
          found = 1'b1;
        end else begin
          n = n + 7'h01;
        end
      end
    end
    if (x == WIDE_ZERO) begin
      n = '0;
    end
    return n[NORM_W-1:0];
  endfunction : norm64

endpackage : wide_alu_pkg

// ==== design/wide_multiplier.sv ====
// signed 32x32 multiplier giving the full 64-bit product
`timescale 1ns/1ps
module wide_multiplier
  import wide_alu_pkg::*;
(
  // operands
  input wire logic [WORD_W-1:0] mul_a,
  input wire logic [WORD_W-1:0] mul_b,
  // product
  output logic [WIDE_W-1:0] product
);

  always_comb begin
    product = WIDE_W'($signed(mul_a)) * WIDE_W'($signed(mul_b));
  end

endmodule : wide_multiplier

// ==== design/wide_shifter.sv ====
// logical shifts and the saturating shift to a word
`timescale 1ns/1ps
module wide_shifter
  import wide_alu_pkg::*;
(
  // operand and signed count
  input wire logic [WIDE_W-1:0] value,
  input wire logic [CNT_W-1:0] count,
  // results
  output logic [WIDE_W-1:0] lshl_value,
  output logic [WIDE_W-1:0] lshr_value,
  output logic [WORD_W-1:0] sat_word,
  output logic sat_hit
);

  logic cnt_neg;
  logic [CNT_W-1:0] mag;
  logic big;
  logic [AMT_W-1:0] amt;
  logic [WIDE_W-1:0] left;
  logic [WIDE_W-1:0] right;
  logic [2*WIDE_W-1:0] ext_left;
  logic [WIDE_W-1:0] ar_right;

  always_comb begin
    cnt_neg = count[CNT_W-1];
    mag = cnt_neg ? (~count + 16'h0001) : count;
    big = (mag >= SHIFT_LIMIT);
    // counts past the width saturate the amount so zero or sign fill results
    amt = big ? AMT_FULL : mag[AMT_W-1:0];
    left = big ? WIDE_ZERO : (value << amt);
    right = big ? WIDE_ZERO : (value >> amt);
  end

  always_comb begin
    lshl_value = cnt_neg ? right : left;
    lshr_value = cnt_neg ? left : right;
  end

  always_comb begin
    ext_left = {{WIDE_W{value[WIDE_W-1]}}, value} << amt;
    ar_right = $signed(value) >>> (big ? AMT_SIGN : amt);
    if (cnt_neg) begin
      sat_word = clamp_word(ar_right);
      sat_hit = (clamp_word(ar_right) != ar_right[WORD_W-1:0]);
    end else if ((ext_left[2*WIDE_W-1:WORD_W-1] == '0) || (ext_left[2*WIDE_W-1:WORD_W-1] == '1)) begin
      sat_word = ext_left[WORD_W-1:0];
      sat_hit = 1'b0;
    end else begin
      sat_word = value[WIDE_W-1] ? WORD_MIN : WORD_MAX;
      sat_hit = 1'b1;
    end
  end

endmodule : wide_shifter

// ==== sim/pipe_sink_model.sv ====
// pipeline side that takes each registered answer
`timescale 1ns/1ps
module pipe_sink_model
  import wide_alu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // answer from the alu
  input wire logic res_valid,
  input wire logic [WIDE_W-1:0] result,
  // what was taken
  output logic [15:0] got_count,
  output logic [WIDE_W-1:0] got_value
);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      got_count <= 16'h0000;
      got_value <= '0;
    end else if (res_valid) begin
      got_count <= got_count + 16'h0001;
      got_value <= result;
    end
  end
endmodule : pipe_sink_model

// ==== sim/tb_fixed_point_wide_accumulator_alu.sv ====
// self-checking bench for the wide accumulator alu
`timescale 1ns/1ps
module tb_fixed_point_wide_accumulator_alu;
  import wide_alu_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  alu_req_s req = '0;
  logic ovf_clear = 1'b0;
  logic res_valid, sat_event, ovf_flag;
  logic [WIDE_W-1:0] result, got_value;
  logic [WORD_W-1:0] result_word;
  logic [HALF_W-1:0] result_half;
  logic [15:0] got_count;
  int fails = 0;
  int n_compared = 0;
  int n_ops = 0;

  wide_acc_alu i_wide_acc_alu (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .ovf_clear(ovf_clear), .res_valid(res_valid), .result(result), .result_word(result_word),
    .result_half(result_half), .sat_event(sat_event), .ovf_flag(ovf_flag));
  pipe_sink_model i_pipe_sink_model (.sys_clk(sys_clk), .reset_n(reset_n), .res_valid(res_valid),
    .result(result), .got_count(got_count), .got_value(got_value));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one request, answer judged one cycle later
  task automatic run(input alu_op_e op, input logic [63:0] a, input logic [63:0] b, input logic [31:0] wa,
                     input logic [31:0] wb, input logic [15:0] c, input logic [63:0] exp);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req = '{op: op, acc: a, wide_b: b, word_a: wa, word_b: wb, half_a: wa[15:0], half_b: wb[15:0], count: c};
    @(negedge sys_clk);
    req_valid = 1'b0;
    n_ops++;
    chk("res_valid", 64'h1, {63'h0, res_valid});
    chk(op.name(), exp, result);
  endtask : run

  task automatic s_back_to_back();
    @(negedge sys_clk);
    req_valid = 1'b1;
    req = '{op: OP_MUL16_INT, half_a: 16'h0003, half_b: 16'h0004, default: '0};
    @(negedge sys_clk);
    req = '{op: OP_MAC16_INT, acc: 64'h64, half_a: 16'h0002, half_b: 16'h0005, default: '0};
    chk("b2b first", 64'hc, result);
    @(negedge sys_clk);
    req_valid = 1'b0;
    n_ops += 2;
    chk("b2b second", 64'h6e, result);
    @(negedge sys_clk);
    chk("idle res_valid", 64'h0, {63'h0, res_valid});
    chk("result holds", 64'h6e, result);
  endtask : s_back_to_back

  task automatic s_multiply();
    run(OP_MSU16_INT, 64'h64, 0, 32'hfffd, 32'h7, 0, 64'h79);
    run(OP_MUL16_FRAC, 0, 0, 32'h8000, 32'h8000, 0, 64'h8000_0000);
    run(OP_MAC16_FRAC, WIDE_MAX, 0, 32'h1, 32'h1, 0, 64'h8000_0000_0000_0001);
    run(OP_MSU16_FRAC, 0, 0, 32'h8000, 32'h8000, 0, 64'hffff_ffff_8000_0000);
    run(OP_MUL32_FRAC, 0, 0, 32'h8000_0000, 32'h8000_0000, 0, WIDE_MAX);
    chk("sat_event frac32 min", 64'h1, {63'h0, sat_event});
    run(OP_MUL32_FRAC, 0, 0, 32'h2, 32'h3, 0, 64'hc);
    run(OP_MUL32_INT, 0, 0, 32'h8000_0000, 32'h8000_0000, 0, 64'h4000_0000_0000_0000);
    run(OP_MUL32_INT, 0, 0, 32'hffff_ffff, 32'h5, 0, 64'hffff_ffff_ffff_fffb);
  endtask : s_multiply

  task automatic s_convert();
    run(OP_DEPOSIT_LO, 0, 0, 32'h8000_0001, 0, 0, 64'hffff_ffff_8000_0001);
    run(OP_DEPOSIT_HI, 0, 0, 32'h1234_5678, 0, 0, 64'h1234_5678_0000_0000);
    run(OP_SAT_WORD, 64'h1_0000_0000, 0, 0, 0, 0, 64'h7fff_ffff);
    chk("sat_event word clamp", 64'h1, {63'h0, sat_event});
    run(OP_SAT_MID, 64'hfff0_0000_0000_0000, 0, 0, 0, 0, 64'hffff_ffff_8000_0000);
    run(OP_SHL_SAT_WORD, 64'h1, 0, 0, 0, 16'h0004, 64'h10);
    run(OP_SHL_SAT_WORD, 64'h100, 0, 0, 0, 16'hfffc, 64'h10);
    run(OP_SHL_SAT_WORD, 64'h1, 0, 0, 0, 16'h001f, 64'h7fff_ffff);
    run(OP_EXTRACT_LO, 64'h1234_5678_9abc_def0, 0, 0, 0, 0, 64'hffff_ffff_9abc_def0);
    chk("low word", 64'h9abc_def0, {32'h0, result_word});
    run(OP_EXTRACT_HI, 64'h1234_5678_9abc_def0, 0, 0, 0, 0, 64'h1234_5678);
    run(OP_ROUND_MID, 64'h1_8000, 0, 0, 0, 0, 64'h2);
    chk("sat_event round mid", 64'h0, {63'h0, sat_event});
    run(OP_ROUND_MID, 64'h1_7fff, 0, 0, 0, 0, 64'h1);
    run(OP_ROUND_HALF, 64'h7fff_8000_0000, 0, 0, 0, 0, 64'h7fff);
    chk("half result", 64'h7fff, {48'h0, result_half});
    chk("sat_event round half", 64'h1, {63'h0, sat_event});
    run(OP_ROUND_TOP, 64'h1_8000_0000, 0, 0, 0, 0, 64'h2);
    run(OP_NORM, 64'h0, 0, 0, 0, 0, 64'h0);
    run(OP_NORM, 64'h1, 0, 0, 0, 0, 64'd62);
    run(OP_NORM, 64'hffff_ffff_ffff_ffff, 0, 0, 0, 0, 64'd63);
  endtask : s_convert

  task automatic s_saturate();
    run(OP_ADD_SAT, WIDE_MAX, 64'h1, 0, 0, 0, WIDE_MAX);
    chk("ovf after add", 64'h1, {63'h0, ovf_flag});
    run(OP_MUL16_INT, 0, 0, 32'h2, 32'h2, 0, 64'h4);
    chk("ovf sticky", 64'h1, {63'h0, ovf_flag});
    ovf_clear = 1'b1;
    @(negedge sys_clk);
    ovf_clear = 1'b0;
    chk("ovf cleared", 64'h0, {63'h0, ovf_flag});
    run(OP_ADD_SAT, 64'h5, 64'hffff_ffff_ffff_fffe, 0, 0, 0, 64'h3);
    chk("ovf no add overflow", 64'h0, {63'h0, ovf_flag});
    chk("sat_event plain add", 64'h0, {63'h0, sat_event});
    run(OP_SUB_SAT, WIDE_MIN, 64'h1, 0, 0, 0, WIDE_MIN);
    chk("ovf after sub", 64'h1, {63'h0, ovf_flag});
    run(OP_NEG_SAT, WIDE_MIN, 0, 0, 0, 0, WIDE_MAX);
    run(OP_ABS_SAT, WIDE_MIN, 0, 0, 0, 0, WIDE_MAX);
    chk("sat_event abs min", 64'h1, {63'h0, sat_event});
    run(OP_ABS_SAT, 64'hffff_ffff_ffff_fffb, 0, 0, 0, 0, 64'h5);
  endtask : s_saturate

  task automatic s_shift();
    run(OP_LSHL, 64'h8000_0000_0000_0001, 0, 0, 0, 16'h0001, 64'h2);
    run(OP_LSHL, 64'h8000_0000_0000_0001, 0, 0, 0, 16'hffff, 64'h4000_0000_0000_0000);
    run(OP_LSHR, 64'h8000_0000_0000_0001, 0, 0, 0, 16'h0001, 64'h4000_0000_0000_0000);
    run(OP_LSHR, 64'h8000_0000_0000_0001, 0, 0, 0, 16'hffff, 64'h2);
  endtask : s_shift

  initial begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    s_back_to_back();
    s_multiply();
    s_convert();
    s_saturate();
    s_shift();
    @(negedge sys_clk);
    chk("answers taken", 64'(n_ops), {48'h0, got_count});
    complete_run();
  end

  // guard against a hung run
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    complete_run();
  end
endmodule : tb_fixed_point_wide_accumulator_alu

// ==== sim/wide_acc_alu_checker.sv ====
// concurrent checks on the ports of the wide accumulator alu
`timescale 1ns/1ps
module wide_acc_alu_checker
  import wide_alu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // request side
  input wire logic req_valid,
  input wire alu_req_s req,
  input wire logic ovf_clear,
  // answer side
  input wire logic res_valid,
  input wire logic [WIDE_W-1:0] result,
  input wire logic [WORD_W-1:0] result_word,
  input wire logic [HALF_W-1:0] result_half,
  input wire logic sat_event,
  input wire logic ovf_flag
);
  logic [WIDE_W-1:0] frac16;
  assign frac16 = ($signed({{48{req.half_a[15]}}, req.half_a}) * $signed({{48{req.half_b[15]}}, req.half_b})) << 1;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_LATENCY: assert property (req_valid |=> res_valid)
    else $error("answer missing one cycle after request");
  AST_IDLE: assert property (!req_valid |=> !res_valid && $stable(result))
    else $error("answer without request or result moved");
  AST_DEP_LO: assert property (req_valid && req.op == OP_DEPOSIT_LO |=>
    result == {{32{$past(req.word_a[31])}}, $past(req.word_a)})
    else $error("low deposit wrong");
  AST_DEP_HI: assert property (req_valid && req.op == OP_DEPOSIT_HI |=> result == {$past(req.word_a), 32'h0})
    else $error("high deposit wrong");
  AST_EXT_HI: assert property (req_valid && req.op == OP_EXTRACT_HI |=> result_word == $past(req.acc[63:32]))
    else $error("high extract wrong");
  AST_ADD_PLAIN: assert property (req_valid && req.op == OP_ADD_SAT && req.acc[63] != req.wide_b[63] |=>
    result == $past(req.acc) + $past(req.wide_b))
    else $error("add without overflow wrong");
  AST_NEG_MIN: assert property (req_valid && req.op == OP_NEG_SAT && req.acc == WIDE_MIN |=>
    result == WIDE_MAX && ovf_flag)
    else $error("negate of minimum not clamped");
  AST_OVF_HOLD: assert property (ovf_flag && !ovf_clear |=> ovf_flag)
    else $error("overflow flag lost without clear");
  AST_FRAC16: assert property (req_valid && req.op == OP_MUL16_FRAC |=> result == $past(frac16))
    else $error("fractional halfword product wrong");
  AST_SAT_WITH_ANSWER: assert property (sat_event |-> res_valid)
    else $error("clamp pulse without an answer");
  AST_FRAC32_MIN: assert property (req_valid && req.op == OP_MUL32_FRAC && req.word_a == WORD_MIN &&
    req.word_b == WORD_MIN |=> result == WIDE_MAX && sat_event)
    else $error("fractional word product of minimum not clamped");
endmodule : wide_acc_alu_checker

bind wide_acc_alu wide_acc_alu_checker i_wide_acc_alu_checker (.sys_clk(sys_clk), .reset_n(reset_n),
  .req_valid(req_valid), .req(req), .ovf_clear(ovf_clear), .res_valid(res_valid), .result(result),
  .result_word(result_word), .result_half(result_half), .sat_event(sat_event), .ovf_flag(ovf_flag));
